//--- logic/motor_position_stop_commands.sv
/*
 * Command interpreter for the absolute-move and gentle-halt frames of a
 * stepper position controller.
 * Assumes an I2C byte front end presenting each received byte as a
 * one-cycle strobe, plus start and stop pulses, all synchronous to clk_i.
 */
// Function
// RULE_01: Valid absolute move loads new target position.
// RULE_02: Master sends address byte then command 0x8B.
// RULE_03: Two filler bytes, high then low signed position.
// RULE_04: Blocked state ignores move, target unchanged.
// RULE_05: Thermal shutdown raises internal gentle halt.
// RULE_06: Halt decelerates to minimum velocity, then stops.
// RULE_07: After stopping, actual position copied into target.
// RULE_08: Master halt frame: address then command 0x8F.
// RULE_09: Wrong address or unknown command is discarded.
`timescale 1ns/100ps
`default_nettype none
module motor_position_stop_commands
    import motor_cmd_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic frame_start_i,
    input wire logic frame_stop_i,
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_data_i,
    input wire logic [3:0] programmable_address_i,
    input wire logic hardwired_address_bit_i,
    input wire logic move_blocked_i,
    input wire logic thermal_shutdown_i,
    input wire logic at_min_velocity_i,
    input wire logic motor_stopped_i,
    input wire logic [POS_W-1:0] actual_position_i,
    output logic [POS_W-1:0] target_position_o,
    output logic target_loaded_o,
    output logic move_ignored_o,
    output logic decelerate_o,
    output logic halt_o,
    output logic frame_discarded_o
);
    typedef enum logic [1:0] {WAIT_FRAME, RECEIVE, SKIP} frame_state_t;
    typedef struct packed {
        frame_state_t st;
        logic [2:0] idx;
        logic is_move;
        logic [7:0] pos_hi;
        logic [POS_W-1:0] target;
        logic loaded;
        logic ignored;
        logic discarded;
        logic halt_req;
        logic therm_prev;
    } cmd_regs_t;

    cmd_regs_t s_q;
    cmd_regs_t s_d;
    logic [7:0] own_address;
    logic addr_match;
    logic cmd_is_move;
    logic cmd_is_halt;
    logic filler_ok;
    logic [POS_W-1:0] received_position;
    logic therm_rise;
    logic halt_frame_end;
    logic partial_frame_end;
    logic copy_pos;
    logic decel_w;
    logic halt_w;

    // The lowest address bit is the write flag, fixed low, so a read request never matches.
    assign own_address = {
        ADDR_TOP_BITS,
        programmable_address_i,
        hardwired_address_bit_i,
        1'b0
    };

    // Byte decodes; they mean something only while the byte strobe is high.
    assign addr_match = (byte_data_i == own_address);
    assign cmd_is_move = (byte_data_i == CMD_ABSOLUTE_MOVE);
    assign cmd_is_halt = (byte_data_i == CMD_GENTLE_HALT);
    assign filler_ok = (byte_data_i == FILLER_BYTE);
    assign received_position = {s_q.pos_hi, byte_data_i}; // [RULE_03]

    // Edge-triggered, so a shutdown held for a long time raises one stop, not a stream.
    assign therm_rise = thermal_shutdown_i && !s_q.therm_prev;

    // A halt frame is known complete only at its stop, after exactly two bytes.
    assign halt_frame_end = (s_q.st == RECEIVE) && !s_q.is_move && (s_q.idx == IDX_FILL0);
    // Any other frame still being received at its stop with at least one byte taken, and not a finished move, was cut short.
    assign partial_frame_end = (s_q.st == RECEIVE) && (s_q.idx != IDX_ADDR)
        && (s_q.idx != IDX_DONE);

    always_comb
    begin
        s_d = s_q;
        s_d.loaded = 1'b0;
        s_d.ignored = 1'b0;
        s_d.discarded = 1'b0;
        s_d.halt_req = 1'b0;
        s_d.therm_prev = thermal_shutdown_i;
        // A rising thermal shutdown behaves exactly like a received halt frame.
        if (therm_rise)
            s_d.halt_req = 1'b1; // [RULE_05]
        if (frame_start_i)
        begin
            s_d.st = RECEIVE;
            s_d.idx = IDX_ADDR;
            s_d.is_move = 1'b0;
        end
        else if (frame_stop_i)
        begin
            // A halt frame acts at its stop; any other unfinished frame is dropped.
            if (halt_frame_end)
                s_d.halt_req = 1'b1; // [RULE_08]
            else if (partial_frame_end)
                s_d.discarded = 1'b1; // [RULE_09]
            s_d.st = WAIT_FRAME;
        end
        else if (byte_valid_i && s_q.st == RECEIVE)
        begin
            s_d.idx = s_q.idx + 3'h1;
            case (s_q.idx)
                IDX_ADDR:
                begin
                    if (!addr_match) // [RULE_02]
                    begin
                        s_d.st = SKIP; // [RULE_09]
                        s_d.discarded = 1'b1;
                    end
                end
                IDX_CMD:
                begin
                    if (cmd_is_move)
                        s_d.is_move = 1'b1;
                    else if (!cmd_is_halt)
                    begin
                        s_d.st = SKIP; // [RULE_09]
                        s_d.discarded = 1'b1;
                    end
                end
                IDX_FILL0, IDX_FILL1:
                begin
                    // Bytes after a halt command or bad filler spoil the frame.
                    if (!s_q.is_move || !filler_ok) // [RULE_03]
                    begin
                        s_d.st = SKIP;
                        s_d.discarded = 1'b1;
                    end
                end
                IDX_POS_HI:
                begin
                    s_d.pos_hi = byte_data_i; // [RULE_03]
                end
                IDX_POS_LO:
                begin
                    // Blocking is judged as the low byte lands, when the move would take effect.
                    if (move_blocked_i)
                        s_d.ignored = 1'b1; // [RULE_04]
                    else
                    begin
                        s_d.target = received_position; // [RULE_01] [RULE_03]
                        s_d.loaded = 1'b1;
                    end
                end
                default:
                begin
                    s_d.st = SKIP;
                    s_d.discarded = 1'b1;
                end
            endcase
        end
        // The copy comes last so it overrides a move landing in the same cycle.
        // That move is then not reported as loaded, since it never took effect.
        if (copy_pos)
        begin
            s_d.target = actual_position_i; // [RULE_07]
            s_d.loaded = 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            s_q.st <= WAIT_FRAME;
            s_q.idx <= IDX_ADDR;
            s_q.is_move <= 1'b0;
            s_q.pos_hi <= 8'h00;
            s_q.target <= TARGET_RESET;
            s_q.loaded <= 1'b0;
            s_q.ignored <= 1'b0;
            s_q.discarded <= 1'b0;
            s_q.halt_req <= 1'b0;
            s_q.therm_prev <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // The sequencer ignores requests while a stop runs, so a repeat halt cannot restart it.
    halt_sequencer u_halt (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .halt_req_i(s_q.halt_req),
        .at_min_velocity_i(at_min_velocity_i),
        .motor_stopped_i(motor_stopped_i),
        .decel_o(decel_w),
        .halt_o(halt_w),
        .copy_pos_o(copy_pos)
    );

    assign target_position_o = s_q.target;
    assign target_loaded_o = s_q.loaded;
    assign move_ignored_o = s_q.ignored;
    assign decelerate_o = decel_w; // [RULE_06]
    assign halt_o = halt_w;
    assign frame_discarded_o = s_q.discarded;
endmodule
`default_nettype wire

//--- common/motor_cmd_pkg.sv
/*
 * Constants for the absolute-move and gentle-halt command interpreter.
 * Assumes a byte-level I2C slave front end that delivers received bytes
 * with start and stop markers.
 */
package motor_cmd_pkg;
    localparam logic [1:0] ADDR_TOP_BITS = 2'h3;
    localparam logic [7:0] CMD_ABSOLUTE_MOVE = 8'h8B;
    localparam logic [7:0] CMD_GENTLE_HALT = 8'h8F;
    localparam logic [7:0] FILLER_BYTE = 8'hFF;
    localparam int POS_W = 16;
    localparam int VEL_W = 4;
    localparam logic [2:0] IDX_ADDR = 3'h0;
    localparam logic [2:0] IDX_CMD = 3'h1;
    localparam logic [2:0] IDX_FILL0 = 3'h2;
    localparam logic [2:0] IDX_FILL1 = 3'h3;
    localparam logic [2:0] IDX_POS_HI = 3'h4;
    localparam logic [2:0] IDX_POS_LO = 3'h5;
    localparam logic [2:0] IDX_DONE = 3'h6;
    localparam logic [15:0] TARGET_RESET = 16'h0000;
endpackage

//--- logic/halt_sequencer.sv
/*
 * Gentle-halt sequencer: asks for deceleration, waits until the motion
 * core reports minimum velocity and standstill, then asks for the target
 * to be overwritten with the actual position.
 * Assumes the motion core reports its state synchronously to clk_i.
 */
`timescale 1ns/100ps
`default_nettype none
module halt_sequencer
    import motor_cmd_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic halt_req_i,
    input wire logic at_min_velocity_i,
    input wire logic motor_stopped_i,
    output logic decel_o,
    output logic halt_o,
    output logic copy_pos_o
);
    typedef enum logic [1:0] {IDLE, DECEL, HALT, COPY} halt_state_t;
    typedef struct packed {
        halt_state_t st;
        logic decel;
        logic halt;
        logic copy;
    } halt_regs_t;

    halt_regs_t s_q;
    halt_regs_t s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.copy = 1'b0;
        case (s_q.st)
            IDLE:
            begin
                if (halt_req_i)
                begin
                    s_d.st = DECEL;
                    s_d.decel = 1'b1; // [RULE_06]
                end
            end
            DECEL:
            begin
                if (at_min_velocity_i)
                begin
                    s_d.st = HALT;
                    s_d.decel = 1'b0;
                    s_d.halt = 1'b1; // [RULE_06]
                end
            end
            HALT:
            begin
                if (motor_stopped_i)
                begin
                    s_d.st = COPY;
                    s_d.copy = 1'b1; // [RULE_07]
                end
            end
            COPY:
            begin
                s_d.st = IDLE;
                s_d.halt = 1'b0;
            end
            default:
            begin
                s_d.st = IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            s_q <= '{st: IDLE, decel: 1'b0, halt: 1'b0, copy: 1'b0};
        else
            s_q <= s_d;
    end

    assign decel_o = s_q.decel;
    assign halt_o = s_q.halt;
    assign copy_pos_o = s_q.copy;
endmodule
`default_nettype wire

//--- verification/motor_cmd_chk.sv
/* Port checker for the command interpreter.
   Assumes move frames arrive with back-to-back position bytes. */
`timescale 1ns/100ps
`default_nettype none
module motor_cmd_chk
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [7:0] byte_data_i,
    input wire logic move_blocked_i,
    input wire logic thermal_shutdown_i,
    input wire logic at_min_velocity_i,
    input wire logic motor_stopped_i,
    input wire logic [15:0] actual_position_i,
    input wire logic [15:0] target_position_o,
    input wire logic target_loaded_o,
    input wire logic move_ignored_o,
    input wire logic decelerate_o,
    input wire logic halt_o,
    input wire logic frame_discarded_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    AST_LOAD_DATA: assert property (target_loaded_o |->
        target_position_o == {$past(byte_data_i, 2), $past(byte_data_i)}) else $error("bad load");
    AST_BLOCK_PICK: assert property ((target_loaded_o || move_ignored_o) |->
        move_ignored_o == $past(move_blocked_i)) else $error("blocking misjudged");
    AST_TGT_CAUSE: assert property (!$stable(target_position_o) |->
        target_loaded_o || $past(halt_o)) else $error("target changed without cause");
    AST_THERMAL: assert property ($rose(thermal_shutdown_i) && !decelerate_o && !halt_o
        |-> ##2 decelerate_o) else $error("no thermal halt");
    AST_DECEL_END: assert property (decelerate_o && at_min_velocity_i |=>
        !decelerate_o && halt_o) else $error("no halt after deceleration");
    AST_HALT_EXCL: assert property (halt_o |-> !decelerate_o)
        else $error("halt and decelerate together");
    AST_COPY: assert property (halt_o && motor_stopped_i |=> ##1 !halt_o &&
        target_position_o == $past(actual_position_i)) else $error("no copy");
    AST_DISCARD: assert property (frame_discarded_o |->
        !target_loaded_o && !move_ignored_o) else $error("discarded frame acted on");
endmodule
bind motor_position_stop_commands motor_cmd_chk u_chk (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .byte_data_i(byte_data_i),
    .move_blocked_i(move_blocked_i),
    .thermal_shutdown_i(thermal_shutdown_i),
    .at_min_velocity_i(at_min_velocity_i),
    .motor_stopped_i(motor_stopped_i),
    .actual_position_i(actual_position_i),
    .target_position_o(target_position_o),
    .target_loaded_o(target_loaded_o),
    .move_ignored_o(move_ignored_o),
    .decelerate_o(decelerate_o),
    .halt_o(halt_o),
    .frame_discarded_o(frame_discarded_o)
);
`default_nettype wire

//--- verification/i2c_cmd_master.sv
/* Byte-level model of the bus master sending command frames.
   Assumes the slave front end has already framed the bytes. */
`timescale 1ns/100ps
`default_nettype none
module i2c_cmd_master
(
    input wire logic clk_i,
    output logic start_o,
    output logic stop_o,
    output logic valid_o,
    output logic [7:0] data_o
);
    initial
    begin
        start_o = 0;
        stop_o = 0;
        valid_o = 0;
        data_o = 8'h00;
    end
    task automatic frame(input logic [7:0] b[$]);
        @(posedge clk_i) #1 start_o = 1;
        @(posedge clk_i) #1 start_o = 0;
        foreach (b[i])
        begin
            valid_o = 1;
            data_o = b[i];
            @(posedge clk_i) #1;
        end
        // A released data line must not keep showing the last byte.
        valid_o = 0;
        data_o = ~data_o;
        stop_o = 1;
        @(posedge clk_i) #1 stop_o = 0;
    endtask
endmodule
`default_nettype wire

//--- verification/motor_position_stop_commands_tb.sv
/* Self-checking bench: frames from the master model, motion core by hand.
   Assumes the checker is bound to the design. */
`timescale 1ns/100ps
`default_nettype none
module motor_position_stop_commands_tb import motor_cmd_pkg::*;;
    logic clk_i = 0, reset_i = 1, start, stop, valid, blk = 0, therm = 0, atmin = 0, stopped = 0;
    logic loaded, ignored, decel, halt, disc, seen_load = 0, seen_ign = 0, seen_disc = 0;
    logic [7:0] data, addr;
    logic [15:0] act = 16'h0000, tgt;
    int num_errors = 0, cmp_count = 0;
    always #50 clk_i = ~clk_i;
    assign addr = {ADDR_TOP_BITS, 4'h5, 1'h1, 1'h0};
    i2c_cmd_master m (.clk_i(clk_i), .start_o(start), .stop_o(stop), .valid_o(valid), .data_o(data));
    motor_position_stop_commands dut (.clk_i(clk_i), .reset_i(reset_i), .frame_start_i(start),
        .frame_stop_i(stop), .byte_valid_i(valid), .byte_data_i(data),
        .programmable_address_i(4'h5), .hardwired_address_bit_i(1'h1), .move_blocked_i(blk),
        .thermal_shutdown_i(therm), .at_min_velocity_i(atmin), .motor_stopped_i(stopped),
        .actual_position_i(act), .target_position_o(tgt), .target_loaded_o(loaded),
        .move_ignored_o(ignored), .decelerate_o(decel), .halt_o(halt), .frame_discarded_o(disc));
    always @(posedge clk_i)
    begin
        seen_load <= seen_load | loaded;
        seen_ign <= seen_ign | ignored;
        seen_disc <= seen_disc | disc;
    end
    task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task move(input logic [15:0] pos);
        seen_load = 0;
        seen_ign = 0;
        seen_disc = 0;
        m.frame('{addr, CMD_ABSOLUTE_MOVE, FILLER_BYTE, FILLER_BYTE, pos[15:8], pos[7:0]});
        repeat (2) @(posedge clk_i) #1;
    endtask
    task halt_seq(input logic [15:0] pos);
        repeat (2) @(posedge clk_i) #1;
        check(decel, 1, "no deceleration");
        atmin = 1;
        repeat (2) @(posedge clk_i) #1;
        atmin = 0;
        check({decel, halt}, 2'h1, "no halt");
        act = pos;
        stopped = 1;
        repeat (3) @(posedge clk_i) #1;
        stopped = 0;
        check(tgt, pos, "stop position not kept");
        check(halt, 0, "halt stuck");
    endtask
    task t_move_and_block;
        move(16'h8001);
        check(seen_load, 1, "move not taken");
        check(tgt, 16'h8001, "signed target");
        check(seen_disc, 0, "complete move discarded");
        blk = 1;
        move(16'h1234);
        blk = 0;
        check({seen_load, seen_ign}, 2'h1, "blocked move");
        check(tgt, 16'h8001, "blocked target moved");
        $display("move test done");
    endtask
    task discard_one(input logic [7:0] b[$]);
        seen_disc = 0;
        seen_load = 0;
        m.frame(b);
        repeat (2) @(posedge clk_i) #1;
        check({seen_disc, seen_load}, 2'h2, "frame kept");
        check({decel, halt, tgt}, 18'h0_8001, "discarded frame acted");
    endtask
    task t_discard;
        discard_one('{addr ^ 8'h04, CMD_GENTLE_HALT});
        discard_one('{addr, 8'h8C});
        discard_one('{addr, CMD_ABSOLUTE_MOVE, FILLER_BYTE, 8'hFE, 8'h12, 8'h34});
        discard_one('{addr, CMD_ABSOLUTE_MOVE, FILLER_BYTE, FILLER_BYTE, 8'h12});
        discard_one('{addr, CMD_GENTLE_HALT, FILLER_BYTE});
        $display("discard test done");
    endtask
    task t_halts;
        m.frame('{addr, CMD_GENTLE_HALT});
        halt_seq(16'h7FFE);
        // Thermal request is edge driven, so the level stays up through the sequence.
        therm = 1;
        @(posedge clk_i) #1;
        halt_seq(16'hC350);
        therm = 0;
        $display("halt test done");
    endtask
    task test_done;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge clk_i) #1;
        reset_i = 0;
        t_move_and_block;
        t_discard;
        t_halts;
        test_done;
    end
    initial
    begin
        repeat (2000) @(posedge clk_i);
        num_errors++;
        test_done;
    end
endmodule
`default_nettype wire
